// ---- inc/smc_pkg.sv ----
package smc_pkg;

	// command codes
	localparam logic [7:0] CMD_OPERATION = 8'h01;
	localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_VIN_MAX = 8'hD0;
	localparam logic [7:0] CMD_TEMP_MAX = 8'hD1;
	localparam logic [7:0] CMD_DAC_CODE = 8'hD2;
	localparam logic [7:0] CMD_GOOD_DELAY = 8'hD3;
	localparam logic [7:0] CMD_WD_FIRST = 8'hD4;
	localparam logic [7:0] CMD_WD_REPEAT = 8'hD5;
	localparam logic [7:0] CMD_PAGE_MASK = 8'hD6;
	localparam logic [7:0] CMD_PADS = 8'hD7;

	// page and field values
	localparam logic [7:0] PAGE_GLOBAL = 8'hFF;
	localparam logic [15:0] PEAK_RST = 16'h7C00;
	localparam logic [5:0] DAC_RSVD = 6'h3F;
	localparam logic [9:0] DAC_RST = 10'h000;
	localparam logic [15:0] TIME_RST = 16'h0000;
	localparam logic [7:0] MASK_RST = 8'hFF;
	localparam int LIN_EXP_MSB = 15;
	localparam int LIN_EXP_LSB = 11;
	localparam int LIN_MAN_MSB = 10;

	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int PG_STEP_US = 200;
	localparam int WD_STEP_US = 10;
	localparam int WF_STEP_US = 1000;
	localparam int PG_MAX_US = 13_100_000;
	localparam int WD_MAX_US = 600_000;
	localparam int WF_MAX_US = 65_000_000;
	localparam int PG_CYCLES = (PG_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WD_CYCLES = (WD_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WF_CYCLES = (WF_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] PG_PER_MS = 7'(1000 / PG_STEP_US);
	localparam logic [6:0] WD_PER_MS = 7'(1000 / WD_STEP_US);
	localparam logic [6:0] WF_PER_MS = 7'(1000 / WF_STEP_US);
	localparam logic [15:0] PG_MAX_TICKS = 16'(PG_MAX_US / PG_STEP_US);
	localparam logic [15:0] WD_MAX_TICKS = 16'(WD_MAX_US / WD_STEP_US);
	localparam logic [15:0] WF_MAX_TICKS = 16'(WF_MAX_US / WF_STEP_US);

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [7:0] page;
		logic [15:0] wdata;
	} smc_cmd_t;

	typedef enum logic [1:0] {WD_OFF, WD_ARMED, WD_FIRST, WD_REPEAT} smc_wd_state_t;

endpackage

// ---- rtl/smc_mfr_regs.sv ----
`timescale 1ns/1ps
module smc_mfr_regs #(
	parameter int CH = 8,
	parameter int WF_CYC = smc_pkg::WF_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire smc_pkg::smc_cmd_t cmd_i,
	output logic [15:0] rdata_o,
	output logic ack_o,
	output logic nack_o,
	input wire logic vin_valid_i,
	input wire logic [15:0] vin_i,
	input wire logic temp_valid_i,
	input wire logic [15:0] temp_i,
	input wire logic dac_manual_i,
	output logic [9:0] dac_code_o,
	input wire logic pg_internal_i,
	input wire logic pg_wdt_cond_i,
	output logic pg_o,
	output logic wdt_expired_o,
	output logic chan_cmd_o,
	output logic [CH-1:0] chan_sel_o,
	input wire logic [15:0] pads_raw_i
);

	// linear value as signed fixed point, 16 fraction bits
	function automatic logic signed [41:0] lin_num(input logic [15:0] v);
		logic signed [41:0] f;
		logic [4:0] sh;
		f = 42'(signed'(v[smc_pkg::LIN_MAN_MSB:0])) <<< 16;
		sh = 5'(-v[smc_pkg::LIN_EXP_MSB:smc_pkg::LIN_EXP_LSB]);
		if (v[smc_pkg::LIN_EXP_MSB] == 1'b0) begin
			f = f <<< v[smc_pkg::LIN_EXP_MSB:smc_pkg::LIN_EXP_LSB];
		end else begin
			f = f >>> sh;
		end
		return f;
	endfunction

	// milliseconds to rounded, capped tick count
	function automatic logic [15:0] lin_ticks(input logic [15:0] v, input logic [6:0] per_ms,
			input logic [15:0] cap);
		logic signed [41:0] n;
		logic [47:0] p;
		logic [31:0] t;
		n = lin_num(v);
		p = 48'(n[40:0]) * 48'(per_ms);
		t = 32'((p + 48'h0000_0000_8000) >> 16);
		if (n <= 42'sh0) begin
			return 16'h0000;
		end else if (t > 32'(cap)) begin
			return cap;
		end else begin
			return t[15:0];
		end
	endfunction

	function automatic logic man_zero(input logic [15:0] v);
		return v[smc_pkg::LIN_MAN_MSB:0] == 11'h000;
	endfunction

	// numeric compare of two linear values
	function automatic logic lin_gt(input logic [15:0] a, input logic [15:0] b);
		return lin_num(a) > lin_num(b);
	endfunction

	logic [15:0] vin_max_r, vin_max_nxt;
	logic [15:0] temp_max_r, temp_max_nxt;
	logic [9:0] dac_r;
	logic [15:0] good_dly_r;
	logic [15:0] wd_first_r;
	logic [15:0] wd_rep_r;
	logic [7:0] mask_r;
	logic [15:0] rdata_r, rdata_nxt;
	logic ack_r;
	logic nack_r;
	logic chan_cmd_r;
	logic [CH-1:0] chan_sel_r;
	logic [31:0] pg_cnt_r;
	logic pg_dly_r;
	logic pg_q_r;
	logic wd_fault_r;
	logic [31:0] wd_cnt_r;
	logic wd_exp_r;
	smc_pkg::smc_wd_state_t wd_state_r, wd_state_nxt;

	// command decode
	wire is_rd = cmd_i.valid & ~cmd_i.write;
	wire is_wr = cmd_i.valid & cmd_i.write;
	wire page_glb = cmd_i.page == smc_pkg::PAGE_GLOBAL;
	wire code_chan = cmd_i.code == smc_pkg::CMD_OPERATION ||
		cmd_i.code == smc_pkg::CMD_ON_OFF_CONFIG;
	wire glb_bad = page_glb & ~code_chan;
	wire hit_clr = cmd_i.code == smc_pkg::CMD_CLEAR_FAULTS;
	wire hit_vin = cmd_i.code == smc_pkg::CMD_VIN_MAX;
	wire hit_temp = cmd_i.code == smc_pkg::CMD_TEMP_MAX;
	wire hit_dac = cmd_i.code == smc_pkg::CMD_DAC_CODE;
	wire hit_good = cmd_i.code == smc_pkg::CMD_GOOD_DELAY;
	wire hit_wf = cmd_i.code == smc_pkg::CMD_WD_FIRST;
	wire hit_wr = cmd_i.code == smc_pkg::CMD_WD_REPEAT;
	wire hit_mask = cmd_i.code == smc_pkg::CMD_PAGE_MASK;
	wire hit_pads = cmd_i.code == smc_pkg::CMD_PADS;
	wire hit_rw = hit_dac | hit_good | hit_wf | hit_wr | hit_mask;
	wire hit_rd = hit_rw | hit_vin | hit_temp | hit_pads;
	wire ok = ~glb_bad;
	wire wr_chan = is_wr & code_chan;
	wire wr_clr = is_wr & ok & hit_clr;
	wire wr_dac = is_wr & ok & hit_dac & dac_manual_i;
	wire wr_good = is_wr & ok & hit_good;
	wire wr_wf = is_wr & ok & hit_wf;
	wire wr_wr = is_wr & ok & hit_wr;
	wire wr_mask = is_wr & ok & hit_mask;
	wire wr_take = wr_chan | wr_clr | wr_dac | wr_good | wr_wf | wr_wr | wr_mask;
	wire rd_take = is_rd & ok & hit_rd;
	wire take = wr_take | rd_take;
	wire refuse = cmd_i.valid & ~take;
	wire wd_restart = wr_wr & ~man_zero(cmd_i.wdata);

	// channel select for forwarded commands
	wire [CH-1:0] page_onehot = (cmd_i.page < 8'(CH)) ?
		CH'(1) << cmd_i.page : '0;
	wire [CH-1:0] chan_sel = page_glb ? mask_r[CH-1:0] : page_onehot;

	// timer loads, in clock cycles
	wire [15:0] pg_ticks = lin_ticks(good_dly_r, smc_pkg::PG_PER_MS,
		smc_pkg::PG_MAX_TICKS);
	wire [15:0] wf_ticks = lin_ticks(wd_first_r, smc_pkg::WF_PER_MS,
		smc_pkg::WF_MAX_TICKS);
	wire [15:0] wr_ticks = lin_ticks(wd_rep_r, smc_pkg::WD_PER_MS,
		smc_pkg::WD_MAX_TICKS);
	wire [31:0] pg_load = 32'(pg_ticks) * 32'(smc_pkg::PG_CYCLES);
	wire [31:0] wf_load = 32'(wf_ticks) * 32'(WF_CYC);
	wire [31:0] wr_load = 32'(wr_ticks) * 32'(smc_pkg::WD_CYCLES);
	wire wd_en = ~man_zero(wd_first_r) & ~man_zero(wd_rep_r);
	wire pg_rise = pg_o & ~pg_q_r;
	wire wd_run = wd_state_r == smc_pkg::WD_FIRST || wd_state_r == smc_pkg::WD_REPEAT;
	wire wd_done = wd_run & (wd_cnt_r == 32'h0000_0000);

	// peaks: clear first, then a larger sample wins
	wire [15:0] vin_base = wr_clr ? smc_pkg::PEAK_RST : vin_max_r;
	wire [15:0] temp_base = wr_clr ? smc_pkg::PEAK_RST : temp_max_r;
	assign vin_max_nxt = (vin_valid_i && lin_gt(vin_i, vin_base)) ?
		vin_i : vin_base;
	assign temp_max_nxt = (temp_valid_i && lin_gt(temp_i, temp_base)) ?
		temp_i : temp_base;

	// read data select
	always_comb begin
		rdata_nxt = rdata_r;
		if (!rd_take) begin
			rdata_nxt = rdata_r;
		end else if (hit_vin) begin
			rdata_nxt = vin_max_r;
		end else if (hit_temp) begin
			rdata_nxt = temp_max_r;
		end else if (hit_dac) begin
			rdata_nxt = {smc_pkg::DAC_RSVD, dac_r};
		end else if (hit_good) begin
			rdata_nxt = good_dly_r;
		end else if (hit_wf) begin
			rdata_nxt = wd_first_r;
		end else if (hit_wr) begin
			rdata_nxt = wd_rep_r;
		end else if (hit_mask) begin
			rdata_nxt = {8'h00, mask_r};
		end else begin
			rdata_nxt = pads_raw_i;
		end
	end

	// watchdog sequencing
	always_comb begin
		wd_state_nxt = wd_state_r;
		case (wd_state_r)
			smc_pkg::WD_OFF: begin
				if (wd_en) begin
					wd_state_nxt = pg_wdt_cond_i ? smc_pkg::WD_ARMED : smc_pkg::WD_FIRST;
				end
			end
			smc_pkg::WD_ARMED: begin
				if (pg_rise) begin
					wd_state_nxt = smc_pkg::WD_FIRST;
				end
			end
			default: begin
				if (pg_wdt_cond_i && !pg_o) begin
					wd_state_nxt = smc_pkg::WD_ARMED;
				end else if (wd_restart || wd_done) begin
					wd_state_nxt = smc_pkg::WD_REPEAT;
				end
			end
		endcase
		if (!wd_en) begin
			wd_state_nxt = smc_pkg::WD_OFF;
		end
	end

	// peak trackers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vin_max_r <= smc_pkg::PEAK_RST;
			temp_max_r <= smc_pkg::PEAK_RST;
		end else begin
			vin_max_r <= vin_max_nxt;
			temp_max_r <= temp_max_nxt;
		end
	end

	// registers written over the command port
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dac_r <= smc_pkg::DAC_RST;
			good_dly_r <= smc_pkg::TIME_RST;
			wd_first_r <= smc_pkg::TIME_RST;
			wd_rep_r <= smc_pkg::TIME_RST;
			mask_r <= smc_pkg::MASK_RST;
		end else begin
			if (wr_dac) begin
				dac_r <= cmd_i.wdata[9:0];
			end
			if (wr_good) begin
				good_dly_r <= cmd_i.wdata;
			end
			if (wr_wf) begin
				wd_first_r <= cmd_i.wdata;
			end
			if (wr_wr) begin
				wd_rep_r <= cmd_i.wdata;
			end
			if (wr_mask) begin
				mask_r <= cmd_i.wdata[7:0];
			end
		end
	end

	// answers and forwarded channel commands
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_r <= 16'h0000;
			ack_r <= 1'b0;
			nack_r <= 1'b0;
			chan_cmd_r <= 1'b0;
			chan_sel_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
			ack_r <= take;
			nack_r <= refuse;
			chan_cmd_r <= wr_chan;
			if (wr_chan) begin
				chan_sel_r <= chan_sel;
			end
		end
	end

	// good output delay
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pg_cnt_r <= 32'h0000_0000;
			pg_dly_r <= 1'b0;
		end else begin
			if (!pg_internal_i) begin
				pg_cnt_r <= pg_load;
				pg_dly_r <= 1'b0;
			end else if (pg_cnt_r != 32'h0000_0000) begin
				pg_cnt_r <= pg_cnt_r - 32'h0000_0001;
			end else begin
				pg_dly_r <= 1'b1;
			end
		end
	end

	// previous good level for the watchdog arm
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pg_q_r <= 1'b0;
		end else begin
			pg_q_r <= pg_o;
		end
	end

	// watchdog state and expiry pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wd_state_r <= smc_pkg::WD_OFF;
			wd_exp_r <= 1'b0;
		end else begin
			wd_state_r <= wd_state_nxt;
			wd_exp_r <= wd_done & wd_en;
		end
	end

	// watchdog interval counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wd_cnt_r <= 32'h0000_0000;
		end else if (wd_state_nxt == smc_pkg::WD_FIRST && !wd_run) begin
			wd_cnt_r <= wf_load;
		end else if (wd_state_nxt == smc_pkg::WD_REPEAT && (wd_restart || wd_done)) begin
			wd_cnt_r <= wr_load;
		end else if (wd_run && wd_cnt_r != 32'h0000_0000) begin
			wd_cnt_r <= wd_cnt_r - 32'h0000_0001;
		end
	end

	// watchdog fault, a set wins over a clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wd_fault_r <= 1'b0;
		end else if (wd_done && wd_en && pg_wdt_cond_i) begin
			wd_fault_r <= 1'b1;
		end else if (wd_restart || !pg_internal_i || !wd_en) begin
			wd_fault_r <= 1'b0;
		end
	end

	assign rdata_o = rdata_r;
	assign ack_o = ack_r;
	assign nack_o = nack_r;
	assign dac_code_o = dac_r;
	assign pg_o = pg_dly_r & ~wd_fault_r;
	assign wdt_expired_o = wd_exp_r;
	assign chan_cmd_o = chan_cmd_r;
	assign chan_sel_o = chan_sel_r;

endmodule // smc_mfr_regs

// ---- verification/smc_host_model.sv ----
`timescale 1ns/1ps
module smc_host_model (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic nack_i,
	output smc_pkg::smc_cmd_t cmd_o
);
	initial cmd_o = '0;
	// one request pulse, answer sampled at the edge after the taking edge
	task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] p,
		input logic [15:0] d, output logic a, output logic na);
		@(posedge clk_i);
		cmd_o <= {1'h1, w, c, p, d};
		@(posedge clk_i);
		cmd_o.valid <= 1'h0;
		@(posedge clk_i);
		a = ack_i;
		na = nack_i;
	endtask
endmodule // smc_host_model

// ---- verification/smc_mfr_regs_chk.sv ----
`timescale 1ns/1ps
module smc_mfr_regs_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire smc_pkg::smc_cmd_t cmd_i,
	input wire logic [15:0] rdata_o,
	input wire logic ack_o,
	input wire logic nack_o,
	input wire logic dac_manual_i,
	input wire logic pg_internal_i,
	input wire logic pg_o,
	input wire logic chan_cmd_o,
	input wire logic [15:0] pads_raw_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire rq = cmd_i.valid && cmd_i.page != smc_pkg::PAGE_GLOBAL;
	wire rd = rq && !cmd_i.write;
	wire wr = rq && cmd_i.write;
	wire glob = cmd_i.valid && cmd_i.page == smc_pkg::PAGE_GLOBAL;
	one_answer_a: assert property (cmd_i.valid |=> ack_o != nack_o)
		else $error("not exactly one answer");
	global_refuse_a: assert property (glob && cmd_i.code != smc_pkg::CMD_OPERATION &&
		cmd_i.code != smc_pkg::CMD_ON_OFF_CONFIG |=> nack_o) else $error("global page taken");
	global_fwd_a: assert property (glob && cmd_i.write &&
		cmd_i.code == smc_pkg::CMD_OPERATION |=> ack_o && chan_cmd_o) else $error("no forward");
	dac_locked_a: assert property (wr && cmd_i.code == smc_pkg::CMD_DAC_CODE &&
		!dac_manual_i |=> nack_o) else $error("dac write outside manual");
	dac_reserved_a: assert property (rd && cmd_i.code == smc_pkg::CMD_DAC_CODE |=>
		ack_o && rdata_o[15:10] == 6'h3F) else $error("dac upper bits");
	pads_raw_a: assert property (rd && cmd_i.code == smc_pkg::CMD_PADS |=>
		rdata_o == $past(pads_raw_i)) else $error("pads value");
	peak_ro_a: assert property (wr && cmd_i.code == smc_pkg::CMD_VIN_MAX |=> nack_o)
		else $error("peak written");
	good_drop_a: assert property (!pg_internal_i |=> !pg_o) else $error("good held");
	good_cause_a: assert property ($rose(pg_o) |-> $past(pg_internal_i))
		else $error("good early");
endmodule // smc_mfr_regs_chk
bind smc_mfr_regs smc_mfr_regs_chk u_chk (.clk_i, .rst_i, .cmd_i, .rdata_o, .ack_o,
	.nack_o, .dac_manual_i, .pg_internal_i, .pg_o, .chan_cmd_o, .pads_raw_i);

// ---- verification/tb_supply_monitor_mfr_command_regs.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_supply_monitor_mfr_command_regs;
	logic clk_i = 1'h0, rst_i = 1'h1, vv = 1'h0, tv = 1'h0, man = 1'h0, pgi = 1'h0, ok;
	logic [15:0] vin = 16'h0, tmp = 16'h0, pads = 16'hA5C3, rd, rdata;
	logic ack, nack, pg, wde;
	logic wdc = 1'h0, nk, cc;
	logic [9:0] dac;
	logic [7:0] sel;
	smc_pkg::smc_cmd_t cmd;
	logic [15:0] rst_tab [6] = '{16'h7C00, 16'h7C00, 16'hFC00, 16'h0, 16'h0, 16'h0};
	int err_count = 0, num_checks = 0, cyc = 0, n;
	smc_mfr_regs #(.WF_CYC(10)) DUT (.clk_i, .rst_i, .cmd_i(cmd), .rdata_o(rdata), .ack_o(ack),
		.nack_o(nack), .vin_valid_i(vv), .vin_i(vin), .temp_valid_i(tv), .temp_i(tmp),
		.dac_manual_i(man), .dac_code_o(dac), .pg_internal_i(pgi), .pg_wdt_cond_i(wdc),
		.pg_o(pg), .wdt_expired_o(wde), .chan_cmd_o(cc), .chan_sel_o(sel), .pads_raw_i(pads));
	smc_host_model host (.clk_i, .ack_i(ack), .nack_i(nack), .cmd_o(cmd));
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			close_out();
		end
	end
	task automatic close_out();
		if (err_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic rw(input logic w, input logic [7:0] c, input logic [15:0] d,
		input logic [7:0] p = 8'h00);
		host.xfer(w, c, p, d, ok, nk);
		rd = rdata;
	endtask
	task automatic samp(input logic t, input logic [15:0] v);
		@(posedge clk_i);
		if (t) begin
			tmp <= v;
			tv <= 1'h1;
		end else begin
			vin <= v;
			vv <= 1'h1;
		end
		@(posedge clk_i);
		tv <= 1'h0;
		vv <= 1'h0;
	endtask
	task automatic gap(output int k);
		k = 0;
		do begin
			@(posedge clk_i);
			#1 k++;
		end while (!wde && k < 300);
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		for (int i = 0; i < 6; i++) begin
			rw(1'h0, smc_pkg::CMD_VIN_MAX + 8'(i), 16'h0);
			`CHK(rd, rst_tab[i])
		end
		rw(1'h0, smc_pkg::CMD_PAGE_MASK, 16'h0);
		`CHK(rd[7:0], 8'hFF)
		samp(1'h0, 16'h0010);
		samp(1'h0, 16'h0005);
		rw(1'h0, smc_pkg::CMD_VIN_MAX, 16'h0);
		`CHK(rd, 16'h0010)
		samp(1'h0, 16'h0809);
		rw(1'h0, smc_pkg::CMD_VIN_MAX, 16'h0);
		`CHK(rd, 16'h0809)
		samp(1'h1, 16'h0003);
		rw(1'h0, smc_pkg::CMD_TEMP_MAX, 16'h0);
		`CHK(rd, 16'h0003)
		rw(1'h1, smc_pkg::CMD_VIN_MAX, 16'h1234);
		`CHK(ok, 1'h0)
		`CHK(nk, 1'h1)
		rw(1'h1, smc_pkg::CMD_CLEAR_FAULTS, 16'h0);
		rw(1'h0, smc_pkg::CMD_TEMP_MAX, 16'h0);
		`CHK(rd, 16'h7C00)
		rw(1'h0, smc_pkg::CMD_VIN_MAX, 16'h0);
		`CHK(rd, 16'h7C00)
		rw(1'h1, smc_pkg::CMD_DAC_CODE, 16'h03AB);
		`CHK(ok, 1'h0)
		`CHK(nk, 1'h1)
		man <= 1'h1;
		rw(1'h1, smc_pkg::CMD_DAC_CODE, 16'h03AB);
		`CHK(dac, 10'h3AB)
		rw(1'h0, smc_pkg::CMD_DAC_CODE, 16'h0);
		`CHK(rd, 16'hFFAB)
		rw(1'h0, smc_pkg::CMD_PADS, 16'h0);
		`CHK(rd, 16'hA5C3)
		rw(1'h1, smc_pkg::CMD_PAGE_MASK, 16'h005A);
		rw(1'h1, smc_pkg::CMD_OPERATION, 16'h0, 8'hFF);
		`CHK(sel, 8'h5A)
		`CHK(cc, 1'h1)
		rw(1'h1, smc_pkg::CMD_ON_OFF_CONFIG, 16'h0, 8'h03);
		`CHK(sel, 8'h08)
		rw(1'h0, smc_pkg::CMD_VIN_MAX, 16'h0, 8'hFF);
		`CHK(ok, 1'h0)
		`CHK(nk, 1'h1)
		rw(1'h1, smc_pkg::CMD_GOOD_DELAY, 16'h0001);
		pgi <= 1'h1;
		repeat (9990) @(posedge clk_i);
		#1 `CHK(pg, 1'h0)
		repeat (20) @(posedge clk_i);
		#1 `CHK(pg, 1'h1)
		rw(1'h1, smc_pkg::CMD_WD_REPEAT, 16'hC801);
		rw(1'h1, smc_pkg::CMD_WD_FIRST, 16'h0002);
		gap(n);
		`CHK(n > 16 && n < 24, 1'h1)
		gap(n);
		`CHK(n > 97 && n < 104, 1'h1)
		repeat (50) @(posedge clk_i);
		rw(1'h1, smc_pkg::CMD_WD_REPEAT, 16'hC801);
		gap(n);
		`CHK(n > 90 && n < 104, 1'h1)
		rw(1'h1, smc_pkg::CMD_WD_FIRST, 16'h0800);
		gap(n);
		`CHK(n, 300)
		rw(1'h1, smc_pkg::CMD_GOOD_DELAY, 16'h0000);
		pgi <= 1'h0;
		wdc <= 1'h1;
		rw(1'h1, smc_pkg::CMD_WD_FIRST, 16'h0002);
		repeat (30) @(posedge clk_i);
		pgi <= 1'h1;
		gap(n);
		`CHK(n > 20 && n < 27, 1'h1)
		`CHK(pg, 1'h0)
		rw(1'h1, smc_pkg::CMD_WD_REPEAT, 16'hC801);
		`CHK(pg, 1'h1)
		close_out();
	end
endmodule // tb_supply_monitor_mfr_command_regs
